// ---- src/clock_pin_routing_defs.vh ----
// constants for the clock source and multifunction pin routing block
// Overview of operation
// R1 - two-bit field picks codec reference clock
// R2 - PLL offers alternative codec clock source
// R3 - oversampling ratio programmable from 1 to 1024; the code holds 1 to 1023 and stores a write of zero as 1
// R4 - PLL input from one of four pins
// R5 - exclusive pin serves only one function
// R6 - master clock pin feeds PLL and codec
// R7 - bit clock pin feeds PLL, codec, interface
// R8 - general pin feeds PLL and codec together
// R9 - pins take default functions after reset
// R10 - strap level picks I2C or SPI control
// R11 - reset and strap pins keep fixed functions
// R12 - power-on reset restores every field default
// R13 - host holds strap level, never changes it
// R14 - each pin select resets to its default
`ifndef CLOCK_PIN_ROUTING_DEFS_VH
`define CLOCK_PIN_ROUTING_DEFS_VH

// ----------------------------------------------------------------
// codec clock source codes (page 0 register 4, bits 1..0)
// ----------------------------------------------------------------
`define CCS_MCLK        2'h0
`define CCS_BCLK        2'h1
`define CCS_GPIO        2'h2
`define CCS_PLL         2'h3
`define CCS_RESET       2'h0

// ----------------------------------------------------------------
// pll input pin codes
// ----------------------------------------------------------------
`define PLLIN_MCLK      2'h0
`define PLLIN_BCLK      2'h1
`define PLLIN_DIN       2'h2
`define PLLIN_GPIO      2'h3
`define PLLIN_RESET     2'h0

// ----------------------------------------------------------------
// oversampling ratio registers and limits
// ----------------------------------------------------------------
`define DAC_OVERSAMPLING_RATIO_MSB_INDEX  8'h0D
`define DAC_OVERSAMPLING_RATIO_LSB_INDEX  8'h0E
`define DAC_OVERSAMPLING_RATIO_MIN        10'h001
`define DAC_OVERSAMPLING_RATIO_RESET      10'h080

// ----------------------------------------------------------------
// strap synchroniser fill count before the first capture
// ----------------------------------------------------------------
`define STRAP_FILL      2'h3

// ----------------------------------------------------------------
// per-pin function codes
// ----------------------------------------------------------------
`define BCLK_FN_IN      1'h0
`define BCLK_FN_OUT     1'h1
`define WCLK_FN_IN      1'h0
`define WCLK_FN_OUT     1'h1
`define DIN_FN_DATA     2'h0
`define DIN_FN_GPI      2'h1
`define DIN_FN_PLL      2'h2
`define GPIO_FN_OFF     2'h0
`define GPIO_FN_GPO     2'h1
`define GPIO_FN_INTERRUPT_OUTPUT_ONE    2'h2
`define GPIO_FN_INTERRUPT_OUTPUT_TWO    2'h3
`define MISO_FN_DATA    2'h0
`define MISO_FN_GPO     2'h1
`define MISO_FN_INTERRUPT_OUTPUT_ONE    2'h2
`define MISO_FN_INTERRUPT_OUTPUT_TWO    2'h3

`endif

// ---- src/audio_clock_source_pin_routing.v ----
// clock source selection and multifunction pin routing
`timescale 1ns/1ps
`include "clock_pin_routing_defs.vh"

module audio_clock_source_pin_routing (
	input  wire       clk,
	input  wire       reset_n,
	input  wire [1:0] codec_clock_source,
	input  wire [1:0] pll_input_select,
	input  wire [7:0] dac_oversampling_ratio_msb_wr,
	input  wire [7:0] dac_oversampling_ratio_lsb_wr,
	input  wire       dac_oversampling_ratio_msb_we,
	input  wire       dac_oversampling_ratio_lsb_we,
	input  wire       bclk_fn,
	input  wire       wclk_fn,
	input  wire [1:0] din_fn,
	input  wire [1:0] gpio_fn,
	input  wire [1:0] miso_fn,
	input  wire       gpo_value,
	input  wire       gpo2_value,
	input  wire       interrupt_output_one_req,
	input  wire       interrupt_output_two_req,
	input  wire       bclk_internal,
	input  wire       wclk_internal,
	input  wire       spi_miso_data,
	input  wire       mclk_pin,
	input  wire       bclk_pin_in,
	input  wire       wclk_pin_in,
	input  wire       din_pin,
	input  wire       gpio_pin_in,
	input  wire       spi_select_strap,
	input  wire       pll_clock,
	output reg  [1:0] codec_clock_source_reg,
	output reg  [1:0] pll_input_select_reg,
	output reg  [9:0] dac_oversampling_ratio_reg,
	output reg        codec_clock_in,
	output reg        pll_clock_in,
	output reg        iface_bclk_in,
	output reg        iface_wclk_in,
	output reg        iface_data_in,
	output reg        gpi_din_reg,
	output wire       bclk_pin_out,
	output wire       bclk_pin_oe_n,
	output wire       wclk_pin_out,
	output wire       wclk_pin_oe_n,
	output wire       gpio_pin_out,
	output wire       gpio_pin_oe_n,
	output wire       miso_pin_out,
	output wire       miso_pin_oe_n,
	output reg        control_is_spi_reg
);

	reg       bclk_fn_reg;
	reg       wclk_fn_reg;
	reg [1:0] din_fn_reg;
	reg [1:0] gpio_fn_reg;
	reg [1:0] miso_fn_reg;
	reg [2:0] strap_sync_reg;
	reg [2:0] din_sync_reg;
	reg       strap_captured_reg;
	reg [1:0] strap_fill_reg;

	// ----------------------------------------------------------------
	// ratio merge helper
	// ----------------------------------------------------------------
	// merge byte writes into the stored ratio; zero folds to the minimum
	// the upper byte only contributes its two low bits
	function [9:0] ratio_merge;
		input [9:0] cur;
		input       msb_we;
		input [7:0] msb;
		input       lsb_we;
		input [7:0] lsb;
		reg   [9:0] raw;
		begin
			raw = {msb_we ? msb[1:0] : cur[9:8], lsb_we ? lsb : cur[7:0]};
			if (raw == 10'h000)
				ratio_merge = `DAC_OVERSAMPLING_RATIO_MIN; // R3
			else
				ratio_merge = raw; // R3
		end
	endfunction

	// ----------------------------------------------------------------
	// configuration fields, all forced to default at reset
	// ----------------------------------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			codec_clock_source_reg     <= `CCS_RESET; // R12
			pll_input_select_reg       <= `PLLIN_RESET;
			dac_oversampling_ratio_reg <= `DAC_OVERSAMPLING_RATIO_RESET;
			bclk_fn_reg                <= `BCLK_FN_IN; // R9
			wclk_fn_reg                <= `WCLK_FN_IN; // R14
			din_fn_reg                 <= `DIN_FN_DATA;
			gpio_fn_reg                <= `GPIO_FN_OFF;
			miso_fn_reg                <= `MISO_FN_DATA;
		end else begin
			codec_clock_source_reg <= codec_clock_source; // R1
			pll_input_select_reg   <= pll_input_select; // R4
			bclk_fn_reg            <= bclk_fn;
			wclk_fn_reg            <= wclk_fn;
			din_fn_reg             <= din_fn;
			gpio_fn_reg            <= gpio_fn; // R5
			miso_fn_reg            <= miso_fn;
			// two-part ratio; either byte may be written alone
			if (dac_oversampling_ratio_msb_we || dac_oversampling_ratio_lsb_we) begin
				dac_oversampling_ratio_reg <= ratio_merge(dac_oversampling_ratio_reg,
				                                          dac_oversampling_ratio_msb_we, dac_oversampling_ratio_msb_wr,
				                                          dac_oversampling_ratio_lsb_we, dac_oversampling_ratio_lsb_wr); // R3
			end
		end
	end

	// ----------------------------------------------------------------
	// strap and pin synchronisers
	// ----------------------------------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_sync_reg     <= 3'h0;
			din_sync_reg       <= 3'h0;
			strap_captured_reg <= 1'h0;
			strap_fill_reg     <= 2'h0;
			control_is_spi_reg <= 1'h0;
			gpi_din_reg        <= 1'h0;
		end else begin
			strap_sync_reg <= {strap_sync_reg[1:0], spi_select_strap};
			din_sync_reg   <= {din_sync_reg[1:0], din_pin};
			// wait until the chain holds only pin samples, not reset zeros
			if (strap_fill_reg != `STRAP_FILL)
				strap_fill_reg <= strap_fill_reg + 2'h1;
			// strap caught once after reset release; host holds it
			if (!strap_captured_reg && strap_fill_reg == `STRAP_FILL &&
			    strap_sync_reg[2] == strap_sync_reg[1]) begin
				strap_captured_reg <= 1'h1; // R13
				control_is_spi_reg <= strap_sync_reg[2]; // R10
			end
			if (din_fn_reg == `DIN_FN_GPI && din_sync_reg[2] == din_sync_reg[1])
				gpi_din_reg <= din_sync_reg[2];
		end
	end

	// ----------------------------------------------------------------
	// clock muxes: shared pins may feed several sinks at once
	// ----------------------------------------------------------------
	// the muxes are plain gates on clock nets; a select change may
	// produce a short pulse, so software should switch sources while
	// the downstream dividers are held off
	// codec reference clock select
	always @* begin
		case (codec_clock_source_reg)
			`CCS_MCLK: codec_clock_in = mclk_pin; // R6
			`CCS_BCLK: codec_clock_in = bclk_pin_in; // R7
			`CCS_GPIO: codec_clock_in = gpio_pin_in; // R8
			`CCS_PLL:  codec_clock_in = pll_clock; // R2
			default:   codec_clock_in = mclk_pin;
		endcase
	end

	// pll reference pin select; data pin only when lent to the pll
	always @* begin
		case (pll_input_select_reg)
			`PLLIN_MCLK: pll_clock_in = mclk_pin; // R6
			`PLLIN_BCLK: pll_clock_in = bclk_pin_in; // R7
			`PLLIN_DIN:  pll_clock_in = (din_fn_reg == `DIN_FN_PLL) ? din_pin : 1'b0; // R5
			`PLLIN_GPIO: pll_clock_in = gpio_pin_in; // R8
			default:     pll_clock_in = mclk_pin;
		endcase
	end

	// audio interface inputs; an output pin loops its own clock back
	always @* begin
		iface_bclk_in = (bclk_fn_reg == `BCLK_FN_IN) ? bclk_pin_in : bclk_internal; // R7
		iface_wclk_in = (wclk_fn_reg == `WCLK_FN_IN) ? wclk_pin_in : wclk_internal;
		iface_data_in = (din_fn_reg == `DIN_FN_DATA) ? din_pin : 1'b0; // R5
	end

	// ----------------------------------------------------------------
	// pin drivers; each exclusive pin drives at most one function
	// ----------------------------------------------------------------
	// output enables are active low; an undriven clock or gpio pin shows a quiet zero
	// on its data line, while an undriven miso pin still carries spi_miso_data
	// bit and word clock pins
	assign bclk_pin_out  = (bclk_fn_reg == `BCLK_FN_OUT) ? bclk_internal : 1'b0;
	assign bclk_pin_oe_n = (bclk_fn_reg != `BCLK_FN_OUT);
	assign wclk_pin_out  = (wclk_fn_reg == `WCLK_FN_OUT) ? wclk_internal : 1'b0;
	assign wclk_pin_oe_n = (wclk_fn_reg != `WCLK_FN_OUT);

	// general-purpose pin: one output source at a time
	assign gpio_pin_out  = (gpio_fn_reg == `GPIO_FN_GPO)  ? gpo_value :
	                       (gpio_fn_reg == `GPIO_FN_INTERRUPT_OUTPUT_ONE) ? interrupt_output_one_req :
	                       (gpio_fn_reg == `GPIO_FN_INTERRUPT_OUTPUT_TWO) ? interrupt_output_two_req : 1'b0; // R5
	assign gpio_pin_oe_n = (gpio_fn_reg == `GPIO_FN_OFF);

	// serial data out pin: control data by default, else one alternate
	assign miso_pin_out  = (miso_fn_reg == `MISO_FN_GPO)  ? gpo2_value :
	                       (miso_fn_reg == `MISO_FN_INTERRUPT_OUTPUT_ONE) ? interrupt_output_one_req :
	                       (miso_fn_reg == `MISO_FN_INTERRUPT_OUTPUT_TWO) ? interrupt_output_two_req : spi_miso_data; // R5
	assign miso_pin_oe_n = (miso_fn_reg == `MISO_FN_DATA) && !control_is_spi_reg; // R11

endmodule // audio_clock_source_pin_routing

// ---- bench/routing_props.sv ----
// checker for clock source and pin routing
`timescale 1ns/1ps
module routing_props (
	input wire       clk, reset_n, bclk_fn, gpo_value, mclk_pin, bclk_pin_in, gpio_pin_in,
	input wire       pll_clock, codec_clock_in, pll_clock_in, iface_bclk_in, bclk_pin_oe_n,
	input wire       gpio_pin_out, gpio_pin_oe_n, spi_select_strap, control_is_spi_reg,
	input wire       dac_oversampling_ratio_msb_we, dac_oversampling_ratio_lsb_we,
	input wire [1:0] codec_clock_source, codec_clock_source_reg, pll_input_select_reg, gpio_fn,
	input wire [7:0] dac_oversampling_ratio_msb_wr, dac_oversampling_ratio_lsb_wr,
	input wire [9:0] dac_oversampling_ratio_reg
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	reg [2:0] up_reg; // edges since reset release, saturating
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) up_reg <= 3'h0;
		else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
	end
	src_sel_a: assert property ($past(reset_n) |-> codec_clock_source_reg == $past(codec_clock_source)) else $error("source select wrong");
	codec_mux_a: assert property (codec_clock_in == (codec_clock_source_reg == 2'h0 ? mclk_pin : codec_clock_source_reg == 2'h1 ? bclk_pin_in : codec_clock_source_reg == 2'h2 ? gpio_pin_in : pll_clock)) else $error("codec clock wrong");
	pll_mux_a: assert property (pll_input_select_reg != 2'h2 |-> pll_clock_in == (pll_input_select_reg == 2'h0 ? mclk_pin : pll_input_select_reg == 2'h1 ? bclk_pin_in : gpio_pin_in)) else $error("pll input wrong");
	dac_oversampling_ratio_write_a: assert property (dac_oversampling_ratio_msb_we && dac_oversampling_ratio_lsb_we |=> dac_oversampling_ratio_reg == ($past({dac_oversampling_ratio_msb_wr[1:0], dac_oversampling_ratio_lsb_wr}) == 10'h000 ? 10'h001 : $past({dac_oversampling_ratio_msb_wr[1:0], dac_oversampling_ratio_lsb_wr}))) else $error("ratio wrong");
	bclk_dir_a: assert property ($past(reset_n) |-> bclk_pin_oe_n == !$past(bclk_fn)) else $error("bclk direction wrong");
	bclk_in_a: assert property ($past(reset_n) && !$past(bclk_fn) |-> iface_bclk_in == bclk_pin_in) else $error("bclk input wrong");
	gpo_excl_a: assert property ($past(reset_n) && $past(gpio_fn) == 2'h1 |-> !gpio_pin_oe_n && gpio_pin_out == gpo_value) else $error("gpio output wrong");
	strap_mode_a: assert property (up_reg == 3'h7 |-> control_is_spi_reg == spi_select_strap) else $error("control mode wrong");
	reset_value_a: assert property (disable iff (1'b0) !reset_n |-> codec_clock_source_reg == 2'h0 && pll_input_select_reg == 2'h0 && dac_oversampling_ratio_reg == 10'h080 && bclk_pin_oe_n && gpio_pin_oe_n && !control_is_spi_reg) else $error("reset value wrong");
	cover property (codec_clock_source_reg == 2'h3);
	cover property (dac_oversampling_ratio_msb_we && dac_oversampling_ratio_lsb_we && dac_oversampling_ratio_lsb_wr == 8'h00);
	cover property ($past(gpio_fn) == 2'h1);
endmodule // routing_props
bind audio_clock_source_pin_routing routing_props props_u (.*);

// ---- bench/host_pin_model.sv ----
// host side model driving clock, data and strap pins
`timescale 1ns/1ps
module host_pin_model #(parameter STRAP = 1'b1) (
	input wire   clk, bclk_pin_out, bclk_pin_oe_n, gpio_pin_out, gpio_pin_oe_n,
	output logic mclk_pin, bclk_pin_in, wclk_pin_in, din_pin, gpio_pin_in, spi_select_strap
);
	logic [7:0] cnt_reg = 8'h00;
	// host clocks move away from the sampling edge
	always @(negedge clk) begin
		cnt_reg <= cnt_reg + 8'h01;
	end
	// wire level is the device driver when enabled, else the host
	assign mclk_pin = cnt_reg[0];
	assign bclk_pin_in = bclk_pin_oe_n ? cnt_reg[1] : bclk_pin_out;
	assign wclk_pin_in = cnt_reg[4];
	assign din_pin = cnt_reg[2] ^ cnt_reg[5];
	assign gpio_pin_in = gpio_pin_oe_n ? cnt_reg[3] : gpio_pin_out;
	assign spi_select_strap = STRAP;
endmodule // host_pin_model

// ---- bench/audio_clock_source_pin_routing_tb.sv ----
// self-checking bench for clock source and pin routing
`timescale 1ns/1ps
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin n_fail++; $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module audio_clock_source_pin_routing_tb;
	logic       clk = 1'b0, reset_n = 1'b1, dac_oversampling_ratio_msb_we = 1'b0, dac_oversampling_ratio_lsb_we = 1'b0, bclk_fn = 1'b0;
	logic       wclk_fn = 1'b0, gpo_value = 1'b0, gpo2_value = 1'b0, interrupt_output_one_req = 1'b0, interrupt_output_two_req = 1'b0;
	logic       bclk_internal = 1'b0, wclk_internal = 1'b0, spi_miso_data = 1'b0, pll_clock = 1'b0;
	logic [1:0] codec_clock_source = 2'h0, pll_input_select = 2'h0, din_fn = 2'h0, gpio_fn = 2'h0;
	logic [1:0] miso_fn = 2'h0;
	logic [7:0] dac_oversampling_ratio_msb_wr = 8'h00, dac_oversampling_ratio_lsb_wr = 8'h00;
	wire        mclk_pin, bclk_pin_in, wclk_pin_in, din_pin, gpio_pin_in, spi_select_strap;
	wire [1:0]  codec_clock_source_reg, pll_input_select_reg;
	wire [9:0]  dac_oversampling_ratio_reg;
	wire        codec_clock_in, pll_clock_in, iface_bclk_in, iface_wclk_in, iface_data_in, gpi_din_reg;
	wire        bclk_pin_out, bclk_pin_oe_n, wclk_pin_out, wclk_pin_oe_n, gpio_pin_out, gpio_pin_oe_n;
	wire        miso_pin_out, miso_pin_oe_n, control_is_spi_reg;
	int         n_fail = 0, check_count = 0;
	logic [31:0] seed = 32'h7EAF;
	audio_clock_source_pin_routing dut_u (.*);
	host_pin_model #(.STRAP(1'b1)) host_u (.*);
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	function automatic logic mux4(input logic [1:0] s, input logic a, b, c, d);
		return s == 2'h0 ? a : s == 2'h1 ? b : s == 2'h2 ? c : d;
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// random selects and a ratio write, checked one edge later
	task automatic step(input logic [9:0] v);
		seed = xs(seed);
		{codec_clock_source, pll_input_select, din_fn, gpio_fn, miso_fn} = seed[9:0];
		{bclk_fn, wclk_fn, gpo_value, interrupt_output_one_req, interrupt_output_two_req, pll_clock} = seed[15:10];
		{gpo2_value, bclk_internal, wclk_internal, spi_miso_data} = seed[25:22];
		{dac_oversampling_ratio_msb_wr, dac_oversampling_ratio_lsb_wr} = {seed[21:16], v};
		dac_oversampling_ratio_msb_we = 1'b1;
		dac_oversampling_ratio_lsb_we = 1'b1;
		@(negedge clk);
		#1;
		`CHK("src_reg", codec_clock_source, codec_clock_source_reg)
		`CHK("codec_in", mux4(codec_clock_source, mclk_pin, bclk_pin_in, gpio_pin_in, pll_clock), codec_clock_in)
		`CHK("pll_in", mux4(pll_input_select, mclk_pin, bclk_pin_in, din_fn == 2'h2 && din_pin, gpio_pin_in), pll_clock_in)
		`CHK("ratio", (v == 10'h000) ? 10'h001 : v, dac_oversampling_ratio_reg)
		`CHK("bclk_oe", !bclk_fn, bclk_pin_oe_n)
		`CHK("wclk_oe", !wclk_fn, wclk_pin_oe_n)
		`CHK("wclk_in", wclk_fn ? wclk_internal : wclk_pin_in, iface_wclk_in)
		`CHK("data_in", (din_fn == 2'h0) ? din_pin : 1'b0, iface_data_in)
		`CHK("gpio_out", mux4(gpio_fn, 1'b0, gpo_value, interrupt_output_one_req, interrupt_output_two_req), gpio_pin_out)
		`CHK("miso_out", mux4(miso_fn, spi_miso_data, gpo2_value, interrupt_output_one_req, interrupt_output_two_req), miso_pin_out)
		`CHK("miso_oe", 1'b0, miso_pin_oe_n)
		if (gpio_fn == 2'h1) `CHK("gpo", {1'b0, gpo_value}, {gpio_pin_oe_n, gpio_pin_out})
		`CHK("spi", 1'b1, control_is_spi_reg)
	endtask
	initial forever #5 clk = ~clk;
	// watchdog well past the expected run
	initial begin
		#100000;
		n_fail++;
		finish_test();
	end
	initial begin
		#1 reset_n = 1'b0;
		repeat (8) @(posedge clk);
		@(negedge clk) reset_n = 1'b1;
		repeat (6) @(negedge clk);
		#1;
		step(10'h000);
		step(10'h001);
		step(10'h3FF);
		repeat (300) step(seed[31:22]);
		@(negedge clk) reset_n = 1'b0;
		#1;
		`CHK("reset", 7'h07, {codec_clock_source_reg, pll_input_select_reg, bclk_pin_oe_n, wclk_pin_oe_n, gpio_pin_oe_n})
		`CHK("reset_ratio", 11'h080, {control_is_spi_reg, dac_oversampling_ratio_reg})
		finish_test();
	end
endmodule // audio_clock_source_pin_routing_tb
